// ---- rtl/slb_line_buffer.sv ----
// Synchronous 8K x 8 line buffer with counter-addressed write and read ports.
// Assumes all pins synchronous to aclk except output_enable_n in async mode;
// configuration is loaded over AXI4-Lite instead of a serial test port.
//
// Contract
// - 8192 x 8 array, separate write and read ports on one clock.
// - Same-location read and write in one cycle returns old word, stores new.
// - Separate read and write counters step only while their port enable is high.
// - Reload input loads the port's reload register, or the cleared value per its control bit, into its counter.
// - Counters wrap 0000 to FFFF counting down, FFFF to 0000 counting up.
// - Counters are 16 bits; low 13 address array, top 3 for depth expansion.
// - Port active only while counter top 3 bits equal control bits 2:0.
// - Mismatched port is inactive but its counter still counts when enabled.
// - Control bit selects synchronous or asynchronous output enable.
// - Both reloads low, enable low: reload both, show read data, no write.
// - Enables high: read counts and reads, write writes and counts; oe gates outputs.
// - Enables low: read counter holds, no write, outputs follow output enable.
// - Read mismatch only: no read, outputs float, write side still works.
// - Read mismatch floats outputs from a rising clock edge.
// - Output enable ignored while read-side expansion bits mismatch.
// - Async output enable acts directly; sync one is sampled on the clock.
// - Input byte stored only with write enable and write-side match.
// - Write reload loads reload register or cleared value per control bit.
// - Read enable loads word at read counter into output register, advances.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
module slb_line_buffer
  import slb_pkg::*;
#(
  parameter int unsigned DEPTH  = slb_pkg::SLB_DEPTH,
  parameter int unsigned DATA_W = slb_pkg::SLB_DATA_W
) (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address and data
  input  wire logic [slb_pkg::SLB_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [slb_pkg::SLB_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Write port
  input  wire logic [DATA_W-1:0]             input_byte,
  input  wire logic                          store_advance,
  input  wire logic                          store_pointer_restore_n,
  // Read port
  input  wire logic                          fetch_advance,
  input  wire logic                          fetch_pointer_restore_n,
  input  wire logic                          output_enable_n,
  output logic [DATA_W-1:0]                  output_byte,
  output logic                               output_byte_oe
);
  import slb_pkg::*;

  localparam int unsigned IDX_W = $clog2(DEPTH);

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Next counter value in the chosen direction
  function automatic logic [15:0] step(input logic [15:0] cnt, input logic down);
    return down ? cnt - 16'h0001 : cnt + 16'h0001;
  endfunction : step

  // Mapped-offset check shared by both bus directions
  function automatic logic mapped(input logic [7:0] a);
    return (a == SLB_CTRL_OFS) || (a == SLB_WRLD_OFS) || (a == SLB_RDLD_OFS) ||
           (a == SLB_WRPTR_OFS) || (a == SLB_RDPTR_OFS);
  endfunction : mapped

  // Storage and state
  logic [DATA_W-1:0]     mem [DEPTH];
  logic [SLB_CTRL_W-1:0] ctrl_q;
  logic [15:0]           wr_reload_q;
  logic [15:0]           rd_reload_q;
  logic [15:0]           wr_cnt_q;
  logic [15:0]           wr_cnt_d;
  logic [15:0]           rd_cnt_q;
  logic [15:0]           rd_cnt_d;
  logic [DATA_W-1:0]     dout_q;
  logic [DATA_W-1:0]     dout_d;
  logic                  oe_n_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [1:0]            rresp_q;
  logic [31:0]           rdata_q;

  // Control fields
  wire logic [2:0] exp_bits  = ctrl_q[SLB_EXP_LSB +: SLB_EXP_W];
  wire logic       wr_clr    = ctrl_q[SLB_WR_CLR_BIT];
  wire logic       rd_clr    = ctrl_q[SLB_RD_CLR_BIT];
  wire logic       oe_async  = ctrl_q[SLB_OE_ASYNC_BIT];
  wire logic       wr_down   = ctrl_q[SLB_WR_DOWN_BIT];
  wire logic       rd_down   = ctrl_q[SLB_RD_DOWN_BIT];

  // Port activity from the expansion bits
  wire logic       wr_match  = (wr_cnt_q[15:SLB_IDX_W] == exp_bits);
  wire logic       rd_match  = (rd_cnt_q[15:SLB_IDX_W] == exp_bits);
  wire logic       wr_reload = !store_pointer_restore_n;
  wire logic       rd_reload = !fetch_pointer_restore_n;
  wire logic       wr_do     = store_advance && !wr_reload && wr_match;
  wire logic [15:0] wr_new   = wr_clr ? SLB_CLEARED : wr_reload_q;
  wire logic [15:0] rd_new   = rd_clr ? SLB_CLEARED : rd_reload_q;
  wire logic       rd_new_match = (rd_new[15:SLB_IDX_W] == exp_bits);
  wire logic       rd_do     = fetch_advance && !rd_reload && rd_match;
  wire logic [IDX_W-1:0] wr_idx = wr_cnt_q[IDX_W-1:0];
  wire logic [IDX_W-1:0] rd_idx = rd_cnt_q[IDX_W-1:0];
  wire logic [DATA_W-1:0] rd_word  = mem[rd_idx];
  wire logic [DATA_W-1:0] rld_word = mem[rd_new[IDX_W-1:0]];

  // Counter and output register next values
  assign wr_cnt_d = wr_reload     ? wr_new :
                    store_advance ? step(wr_cnt_q, wr_down) : wr_cnt_q;
  assign rd_cnt_d = rd_reload     ? rd_new :
                    fetch_advance ? step(rd_cnt_q, rd_down) : rd_cnt_q;
  assign dout_d   = (rd_reload && rd_new_match) ? rld_word :
                    rd_do ? rd_word : dout_q;

  // Output drive: mismatch overrides either output-enable mode
  assign output_byte    = dout_q;
  assign output_byte_oe = rd_match && (oe_async ? !output_enable_n : !oe_n_q);

  // Array write; read above uses the pre-edge contents
  always_ff @(posedge aclk) begin
    if (wr_do) begin
      mem[wr_idx] <= input_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_cnt_q <= SLB_RELOAD_RST;
      rd_cnt_q <= SLB_RELOAD_RST;
      dout_q   <= SLB_DOUT_RST;
      oe_n_q   <= 1'b1;
    end else begin
      wr_cnt_q <= wr_cnt_d;
      rd_cnt_q <= rd_cnt_d;
      dout_q   <= dout_d;
      oe_n_q   <= output_enable_n;
    end
  end

  // Register bus: both write channels are taken together, one answer at a time
  wire logic        wr_take   = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire logic        rd_take   = s_axi_arvalid && !rvalid_q;
  wire logic [31:0] ctrl_wide = {{(32-SLB_CTRL_W){1'b0}}, ctrl_q};
  wire logic [31:0] ctrl_mrg  = lane_merge(ctrl_wide, s_axi_wdata, s_axi_wstrb);
  wire logic [31:0] wrld_mrg  = lane_merge({16'h0000, wr_reload_q}, s_axi_wdata, s_axi_wstrb);
  wire logic [31:0] rdld_mrg  = lane_merge({16'h0000, rd_reload_q}, s_axi_wdata, s_axi_wstrb);
  wire logic [31:0] rd_value  =
    (s_axi_araddr == SLB_CTRL_OFS)  ? ctrl_wide :
    (s_axi_araddr == SLB_WRLD_OFS)  ? {16'h0000, wr_reload_q} :
    (s_axi_araddr == SLB_RDLD_OFS)  ? {16'h0000, rd_reload_q} :
    (s_axi_araddr == SLB_WRPTR_OFS) ? {16'h0000, wr_cnt_q} :
    (s_axi_araddr == SLB_RDPTR_OFS) ? {16'h0000, rd_cnt_q} : 32'h0000_0000;

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= SLB_CTRL_RST;
      wr_reload_q <= SLB_RELOAD_RST;
      rd_reload_q <= SLB_RELOAD_RST;
    end else if (wr_take) begin
      if (s_axi_awaddr == SLB_CTRL_OFS) begin
        ctrl_q <= ctrl_mrg[SLB_CTRL_W-1:0];
      end
      if (s_axi_awaddr == SLB_WRLD_OFS) begin
        wr_reload_q <= wrld_mrg[15:0];
      end
      if (s_axi_awaddr == SLB_RDLD_OFS) begin
        rd_reload_q <= rdld_mrg[15:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= SLB_RESP_OKAY;
    end else if (wr_take) begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(s_axi_awaddr) ? SLB_RESP_OKAY : SLB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= SLB_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= mapped(s_axi_araddr) ? SLB_RESP_OKAY : SLB_RESP_SLVERR;
      rdata_q  <= rd_value;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Checks
  logic [IDX_W-1:0]  last_wr_idx_q;
  logic [DATA_W-1:0] last_wr_dat_q;
  logic              last_wr_q;
  wire logic [DATA_W-1:0] last_wr_mem = mem[last_wr_idx_q];
  wire logic [DATA_W-1:0] wr_word     = mem[wr_idx];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_wr_q <= 1'b0;
    end else begin
      last_wr_q <= wr_do;
    end
    last_wr_idx_q <= wr_idx;
    last_wr_dat_q <= input_byte;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_step_up;
    fetch_advance && fetch_pointer_restore_n && !rd_down;
  endsequence

  sequence s_rd_idle;
    !fetch_advance && fetch_pointer_restore_n;
  endsequence

  chk_rd_count_up: assert property (s_rd_step_up |=> rd_cnt_q == $past(rd_cnt_q) + 16'h0001)
    else $error("read counter did not step up");
  chk_rd_wrap_up: assert property ((rd_cnt_q == 16'hFFFF) and s_rd_step_up |=> rd_cnt_q == 16'h0000)
    else $error("read counter did not wrap to zero");
  chk_rd_hold_idle: assert property (s_rd_idle |=> $stable(rd_cnt_q) && $stable(output_byte))
    else $error("read side moved while idle");
  chk_rd_reload_copy: assert property (rd_reload && !rd_clr |=> rd_cnt_q == $past(rd_reload_q))
    else $error("read reload did not copy register");
  chk_wr_mismatch_count: assert property (store_advance && !wr_match && !wr_reload && !wr_down
                                          |=> wr_cnt_q == $past(wr_cnt_q) + 16'h0001)
    else $error("write counter stopped while mismatched");
  chk_wr_store_word: assert property (last_wr_q |-> last_wr_mem == last_wr_dat_q)
    else $error("written byte not in array");
  chk_rd_float_mismatch: assert property (!rd_match |-> !output_byte_oe)
    else $error("outputs driven on read mismatch");
  chk_oe_sync_mode: assert property (!oe_async && rd_match && $past(output_enable_n) |-> !output_byte_oe)
    else $error("sync output enable not honoured");
  chk_oe_async_mode: assert property (oe_async && rd_match |-> output_byte_oe == !output_enable_n)
    else $error("async output enable not direct");
  chk_rd_old_word: assert property (rd_do && wr_do && rd_idx == wr_idx |=> output_byte == $past(rd_word))
    else $error("collision did not return old word");

  // Write side: steps, reloads and refused stores
  sequence s_wr_step_up;
    store_advance && store_pointer_restore_n && !wr_down;
  endsequence

  sequence s_wr_step_down;
    store_advance && store_pointer_restore_n && wr_down;
  endsequence

  sequence s_wr_blocked;
    store_advance && store_pointer_restore_n && !wr_match;
  endsequence

  chk_wr_count_up: assert property (s_wr_step_up
                                    |=> wr_cnt_q == $past(wr_cnt_q) + 16'h0001)
    else $error("write counter did not step up");
  chk_wr_count_down: assert property (s_wr_step_down
                                      |=> wr_cnt_q == $past(wr_cnt_q) - 16'h0001)
    else $error("write counter did not step down");
  chk_wr_wrap_down: assert property ((wr_cnt_q == 16'h0000) and s_wr_step_down
                                     |=> wr_cnt_q == 16'hFFFF)
    else $error("write counter did not wrap to top");
  chk_wr_reload_copy: assert property (wr_reload && !wr_clr
                                       |=> wr_cnt_q == $past(wr_reload_q))
    else $error("write reload did not copy register");
  chk_wr_reload_clear: assert property (wr_reload && wr_clr |=> wr_cnt_q == SLB_CLEARED)
    else $error("write reload did not clear counter");
  chk_wr_no_store: assert property (s_wr_blocked |=> mem[$past(wr_idx)] == $past(wr_word))
    else $error("array written on expansion mismatch");
  chk_wr_reload_keep: assert property (wr_reload |=> mem[$past(wr_idx)] == $past(wr_word))
    else $error("array written during write reload");

  // Read side: reloads, reads and mismatch behaviour
  sequence s_rd_blocked;
    fetch_advance && fetch_pointer_restore_n && !rd_match;
  endsequence

  chk_rd_reload_clear: assert property (rd_reload && rd_clr |=> rd_cnt_q == SLB_CLEARED)
    else $error("read reload did not clear counter");
  chk_rd_reload_word: assert property (rd_reload && rd_new_match
                                       |=> output_byte == $past(rld_word))
    else $error("read reload did not load output");
  chk_rd_read_word: assert property (rd_do |=> output_byte == $past(rd_word))
    else $error("read did not load output register");
  chk_rd_no_read: assert property (s_rd_blocked |=> $stable(output_byte))
    else $error("output changed on read mismatch");
  chk_rd_mismatch_count: assert property (s_rd_blocked and (!rd_down)
                                          |=> rd_cnt_q == $past(rd_cnt_q) + 16'h0001)
    else $error("read counter stopped while mismatched");
  chk_oe_ignored: assert property (!rd_match && !output_enable_n |-> !output_byte_oe)
    else $error("output enable obeyed on mismatch");
  chk_oe_sync_on: assert property (!oe_async && rd_match && $past(aresetn) && !$past(output_enable_n)
                                   |-> output_byte_oe)
    else $error("sync output enable failed to drive");

  // Register bus answers one cycle after the take
  chk_bus_b_answer: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  chk_bus_r_answer: assert property (rd_take
                                     |=> s_axi_rvalid && s_axi_rdata == $past(rd_value))
    else $error("read response missing");

endmodule : slb_line_buffer

// ---- rtl/slb_pkg.sv ----
// Package for the synchronous line buffer: register map, field positions,
// reset values and cycle figures.
// Assumes one 125 MHz clock and an AXI4-Lite register port with 32-bit data.
package slb_pkg;

  localparam int unsigned SLB_DEPTH      = 8192;
  localparam int unsigned SLB_DATA_W     = 8;
  localparam int unsigned SLB_CNT_W      = 16;
  localparam int unsigned SLB_IDX_W      = 13;
  localparam int unsigned SLB_EXP_W      = 3;
  localparam int unsigned SLB_ADDR_W     = 8;

  // Register byte offsets
  localparam logic [7:0]  SLB_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  SLB_WRLD_OFS    = 8'h04;
  localparam logic [7:0]  SLB_RDLD_OFS    = 8'h08;
  localparam logic [7:0]  SLB_WRPTR_OFS   = 8'h0C;
  localparam logic [7:0]  SLB_RDPTR_OFS   = 8'h10;

  // Control register fields
  localparam int unsigned SLB_CTRL_W      = 10;
  localparam int unsigned SLB_EXP_LSB     = 0;
  localparam int unsigned SLB_WR_CLR_BIT  = 3;
  localparam int unsigned SLB_RD_CLR_BIT  = 5;
  localparam int unsigned SLB_OE_ASYNC_BIT = 7;
  localparam int unsigned SLB_WR_DOWN_BIT = 8;
  localparam int unsigned SLB_RD_DOWN_BIT = 9;

  // Values after reset
  localparam logic [9:0]  SLB_CTRL_RST    = 10'h000;
  localparam logic [15:0] SLB_RELOAD_RST  = 16'h0000;
  localparam logic [15:0] SLB_CLEARED     = 16'h0000;
  localparam logic [7:0]  SLB_DOUT_RST    = 8'h00;

  // AXI responses
  localparam logic [1:0]  SLB_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  SLB_RESP_SLVERR = 2'b10;

  // Cycle figures of the register port
  localparam int unsigned SLB_BUS_LAT     = 1;

endpackage : slb_pkg

// ---- test/slb_stream_partner.sv ----
// Stream partner: upstream byte source on the write port and downstream
// receiver of the read port. Expects drive() to be called just after a rising edge.
module slb_stream_partner (
  // Clock
  input  wire logic       aclk,
  // Write port source
  output logic [7:0]      input_byte,
  output logic            store_advance,
  output logic            store_pointer_restore_n,
  // Read port receiver
  input  wire logic [7:0] output_byte,
  input  wire logic       output_byte_oe,
  output logic [7:0]      seen_byte
);
  logic [7:0] last_q;

  initial begin
    input_byte = 8'h00;
    store_advance = 1'b0;
    store_pointer_restore_n = 1'b1;
  end

  // A floated bus shows the inverse of the last driven byte
  assign seen_byte = output_byte_oe ? output_byte : ~last_q;

  always_ff @(posedge aclk) begin
    if (output_byte_oe) begin
      last_q <= output_byte;
    end
  end

  // Changes only just after an edge, so inputs stay stable around the next one
  task drive(input logic sa, input logic srn, input logic [7:0] d);
    store_advance <= sa;
    store_pointer_restore_n <= srn;
    input_byte <= d;
  endtask : drive
endmodule : slb_stream_partner

// ---- test/synchronous_line_buffer_test.sv ----
// Self-checking bench for the line buffer: registers over AXI4-Lite,
// write port fed and read port watched by the stream partner.
module synchronous_line_buffer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import slb_pkg::*;
  localparam logic [1:0] OK = SLB_RESP_OKAY;
  localparam logic [7:0] CT = SLB_CTRL_OFS;
  localparam logic [7:0] WP = SLB_WRPTR_OFS;
  localparam logic [7:0] RP = SLB_RDPTR_OFS;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        fetch_advance, fetch_pointer_restore_n, output_enable_n;
  logic [7:0]  awaddr, araddr, input_byte, output_byte, seen_byte;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, output_byte_oe;
  logic        store_advance, store_pointer_restore_n;
  int          num_errors, n_tests;

  slb_line_buffer i_slb_line_buffer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .input_byte(input_byte), .store_advance(store_advance),
    .store_pointer_restore_n(store_pointer_restore_n), .fetch_advance(fetch_advance),
    .fetch_pointer_restore_n(fetch_pointer_restore_n), .output_enable_n(output_enable_n),
    .output_byte(output_byte), .output_byte_oe(output_byte_oe));

  slb_stream_partner i_slb_stream_partner (.aclk(aclk), .input_byte(input_byte),
    .store_advance(store_advance), .store_pointer_restore_n(store_pointer_restore_n),
    .output_byte(output_byte), .output_byte_oe(output_byte_oe), .seen_byte(seen_byte));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One register access; waits for each handshake, checks response and read data
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    awvalid <= wr;
    wvalid  <= wr;
    arvalid <= !wr;
    bready  <= wr;
    rready  <= !wr;
    do @(negedge aclk); while ((wr ? awready & wready : arready) !== 1'b1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    arvalid <= 1'b0;
    do @(negedge aclk); while ((wr ? bvalid : rvalid) !== 1'b1);
    chk("resp", {30'h0, r}, {30'h0, wr ? bresp : rresp});
    if (!wr) chk("rdata", d, rdata);
    @(posedge aclk);
    bready <= 1'b0;
    rready <= 1'b0;
  endtask : axi

  // One port cycle, driven after an edge; returns at the following falling edge
  task automatic cyc(input logic sa, srn, fa, frn, oen, input logic [7:0] d);
    @(posedge aclk);
    i_slb_stream_partner.drive(sa, srn, d);
    fetch_advance <= fa;
    fetch_pointer_restore_n <= frn;
    output_enable_n <= oen;
    @(negedge aclk);
  endtask : cyc

  task automatic idle;
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
  endtask : idle

  task automatic out(input logic oe, input logic [7:0] b);
    chk("oe", {31'h0, oe}, {31'h0, output_byte_oe});
    chk("bus", {24'h0, oe ? b : ~b}, {24'h0, seen_byte});
  endtask : out

  task automatic t_regs;
    logic [7:0] ofs [5] = '{CT, SLB_WRLD_OFS, SLB_RDLD_OFS, WP, RP};
    foreach (ofs[i]) axi(1'b0, ofs[i], 32'h0, OK);
    axi(1'b0, 8'h14, 32'h0, SLB_RESP_SLVERR);
    axi(1'b1, 8'h14, 32'hFFFF_FFFF, SLB_RESP_SLVERR);
    axi(1'b1, WP, 32'h1234, OK);
    axi(1'b0, WP, 32'h0, OK);
    chk("oe", 32'h0, {31'h0, output_byte_oe});
  endtask : t_regs

  task automatic t_stream;
    for (int i = 0; i < 4; i++) cyc(1, 1, 0, 1, 0, 8'hA0 + 8'(i));
    idle;
    axi(1'b0, WP, 32'h4, OK);
    cyc(1, 0, 0, 0, 0, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      cyc(0, 1, 1, 1, 0, 8'h00);
      out(1'b1, (i == 0) ? 8'hA0 : 8'hA0 + 8'(i - 1));
    end
    idle;
    out(1'b1, 8'hA3);
    idle;
    out(1'b1, 8'hA3);
    axi(1'b0, RP, 32'h4, OK);
    axi(1'b0, WP, 32'h0, OK);
  endtask : t_stream

  task automatic t_same;
    cyc(0, 0, 0, 0, 0, 8'h00);
    cyc(1, 1, 1, 1, 0, 8'hC3);
    out(1'b1, 8'hA0);
    cyc(0, 1, 0, 0, 0, 8'h00);
    out(1'b1, 8'hA0);
    idle;
    out(1'b1, 8'hC3);
  endtask : t_same

  task automatic t_oe;
    cyc(0, 1, 0, 1, 1, 8'h00);
    out(1'b1, 8'hC3);
    cyc(0, 1, 0, 1, 1, 8'h00);
    out(1'b0, 8'hC3);
    idle;
    out(1'b0, 8'hC3);
    axi(1'b1, CT, 32'h80, OK);
    cyc(0, 1, 0, 1, 1, 8'h00);
    out(1'b0, 8'hC3);
    idle;
    out(1'b1, 8'hC3);
    axi(1'b1, CT, 32'h0, OK);
  endtask : t_oe

  task automatic t_wrap;
    axi(1'b1, SLB_WRLD_OFS, 32'hFFFF, OK);
    axi(1'b1, SLB_RDLD_OFS, 32'h2005, OK);
    cyc(0, 0, 0, 0, 0, 8'h00);
    cyc(1, 1, 1, 1, 0, 8'h77);
    out(1'b0, 8'hC3);
    idle;
    out(1'b0, 8'hC3);
    axi(1'b0, WP, 32'h0, OK);
    axi(1'b0, RP, 32'h2006, OK);
    axi(1'b1, CT, 32'h301, OK);
    cyc(1, 1, 0, 1, 0, 8'h99);
    idle;
    out(1'b1, 8'hC3);
    axi(1'b0, WP, 32'hFFFF, OK);
  endtask : t_wrap

  task automatic t_clear;
    axi(1'b1, CT, 32'h28, OK);
    cyc(0, 0, 0, 0, 0, 8'h00);
    idle;
    out(1'b1, 8'hC3);
    axi(1'b0, WP, 32'h0, OK);
    axi(1'b0, RP, 32'h0, OK);
    axi(1'b1, SLB_RDLD_OFS, 32'h2000, OK);
    axi(1'b1, CT, 32'h8, OK);
    cyc(0, 0, 0, 0, 0, 8'h00);
    cyc(1, 1, 1, 1, 0, 8'h4D);
    out(1'b0, 8'hC3);
    idle;
    out(1'b0, 8'hC3);
    axi(1'b1, CT, 32'h28, OK);
    cyc(0, 1, 0, 0, 0, 8'h00);
    idle;
    out(1'b1, 8'h4D);
  endtask : t_clear

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    finish_test;
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {fetch_advance, fetch_pointer_restore_n, output_enable_n} = 3'b011;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_stream;
    t_same;
    t_oe;
    t_wrap;
    t_clear;
    finish_test;
  end
endmodule : synchronous_line_buffer_test
